// [inc/display_host_interface_defs.svh]
// constants for the display host interface: strap codes, i2c framing, reset values
`ifndef DISPLAY_HOST_INTERFACE_DEFS_SVH
`define DISPLAY_HOST_INTERFACE_DEFS_SVH

`define STRAP_SERIAL4       2'h0
`define STRAP_PAR_RWSEL     2'h1
`define STRAP_I2C           2'h2
`define STRAP_PAR_STROBE    2'h3

`define I2C_BITS_PER_BYTE   4'h8
`define I2C_CTRL_DC_BIT     6
`define I2C_RW_WRITE        1'h0

`define SPI_LAST_BIT        3'h7

`define COL_ADDR_RESET      8'h00
`define BYTE_RESET          8'h00
`define BUS_ALL_DRIVEN      8'hff
`define BUS_RELEASED        8'h00
`define SDA_LINE_BIT        1

`endif

// [inc/display_host_pkg.sv]
// shared types of the display host interface
package display_host_pkg;

    typedef enum logic [1:0] {
        IFACE_SERIAL4    = 2'h0,
        IFACE_PAR_RWSEL  = 2'h1,
        IFACE_I2C        = 2'h2,
        IFACE_PAR_STROBE = 2'h3
    } iface_mode_e;

    typedef enum logic [3:0] {
        I2C_IDLE   = 4'h1,
        I2C_SHIFT  = 4'h2,
        I2C_ACK    = 4'h4,
        I2C_IGNORE = 4'h8
    } i2c_state_e;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_CTRL = 3'h2,
        PH_DATA = 3'h4
    } i2c_phase_e;

    typedef struct packed {
        logic       is_data;
        logic [7:0] value;
    } rx_byte_s;

endpackage : display_host_pkg

// [rtl/bit_sync.sv]
// two flip-flop level synchroniser, one stage pair per bit
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                meta_r[g] <= async_i[g];
                sync_o[g] <= meta_r[g];
            end
        end
    endgenerate

endmodule : bit_sync

// [rtl/spi_shifter.sv]
// 4-wire serial receiver running on the host serial clock
`include "display_host_interface_defs.svh"

module spi_shifter (
    input  wire logic                      sclk_i,
    input  wire logic                      clear_i,
    input  wire logic                      cs_n_i,
    input  wire logic                      serial_data_in_i,
    input  wire logic                      dc_i,
    output display_host_pkg::rx_byte_s     rx_o,
    output logic                           toggle_o
);

    logic       clr_meta_r;
    logic       clr_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;

    // clear asserts at once, since the serial clock is stopped while the system initialises;
    // its release is retimed by two serial clock edges
    always_ff @(posedge sclk_i or posedge clear_i) begin
        if (clear_i) begin
            clr_meta_r <= 1'b1;
            clr_r      <= 1'b1;
        end else begin
            clr_meta_r <= 1'b0;
            clr_r      <= clr_meta_r;
        end
    end

    // deselect ends the frame by itself, since the serial clock stops outside frames
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_r <= 3'h0;
        end else if (clr_r) begin
            bit_cnt_r <= 3'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge sclk_i or posedge clr_r) begin
        if (clr_r) begin
            shift_r <= 7'h00;
        end else if (!cs_n_i) begin
            shift_r <= {shift_r[5:0], serial_data_in_i};
        end
    end

    // byte and its flag are held stable until the next byte completes
    always_ff @(posedge sclk_i or posedge clr_r) begin
        if (clr_r) begin
            rx_o     <= '0;
            toggle_o <= 1'b0;
        end else if (!cs_n_i && bit_cnt_r == `SPI_LAST_BIT) begin
            rx_o.value   <= {shift_r, serial_data_in_i};
            rx_o.is_data <= dc_i;
            toggle_o     <= ~toggle_o;
        end
    end

endmodule : spi_shifter

// [rtl/display_host_interface.sv]
// host port of a display driver: strapped parallel, serial and i2c front ends
`include "display_host_interface_defs.svh"
module display_host_interface #(
    parameter logic [5:0] I2C_ADDR_HI = 6'h1e,
    parameter int         COL_W       = 8,
    parameter logic [7:0] NUM_COLS    = 8'ha0
) (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          link_clk_i,
    input  wire logic                          reset_n_in_i,
    input  wire logic                          cs_n_i,
    input  wire logic                          dc_i,
    input  wire logic                          iface_strap_hi_i,
    input  wire logic                          iface_strap_lo_i,
    input  wire logic                          rw_wr_n_i,
    input  wire logic                          e_rd_n_i,
    input  wire logic [7:0]                    data_i,
    input  wire logic [7:0]                    rd_data_i,
    input  wire logic                          disp_on_set_i,
    input  wire logic                          disp_on_clr_i,
    output logic      [7:0]                    data_o,
    output logic      [7:0]                    data_oe_o,
    output logic      [7:0]                    cmd_o,
    output logic                               cmd_we_o,
    output logic      [7:0]                    disp_data_o,
    output logic                               disp_we_o,
    output logic      [COL_W-1:0]              col_addr_o,
    output logic                               display_on_o,
    output logic                               rd_done_o,
    output display_host_pkg::iface_mode_e      mode_o,
    output logic                               init_o
);

    localparam int PIN_W = 15;

    logic [PIN_W-1:0]              pin_raw;
    logic [PIN_W-1:0]              pin_s;
    logic [PIN_W-1:0]              pin_d;
    logic                          reset_n_s;
    logic                          cs_n_s;
    logic                          dc_s;
    logic                          rw_s;
    logic                          e_s;
    logic [7:0]                    bus_s;
    logic                          cs_n_d;
    logic                          dc_d;
    logic                          rw_d;
    logic                          e_d;
    logic [7:0]                    bus_d;
    logic                          init_r;
    display_host_pkg::iface_mode_e mode_r;
    logic                          spi_clear_r;
    display_host_pkg::rx_byte_s    spi_rx;
    logic                          spi_tog;
    logic                          spi_tog_s;
    logic                          spi_tog_d;
    logic                          scl_s;
    logic                          sda_s;
    logic                          scl_d;
    logic                          sda_d;
    logic                          i2c_start;
    logic                          i2c_stop;
    logic                          scl_rise;
    logic                          scl_fall;
    display_host_pkg::i2c_state_e  i2c_state_r;
    display_host_pkg::i2c_phase_e  i2c_phase_r;
    logic [3:0]                    i2c_cnt_r;
    logic [7:0]                    i2c_sh_r;
    logic                          i2c_dc_r;
    logic                          i2c_evt_r;
    logic                          i2c_drive_r;
    logic                          i2c_data_sense;
    logic                          slave_addr_lsb;
    logic                          par_read;
    logic                          wr_evt;
    logic [7:0]                    wr_byte;
    logic                          wr_is_data;
    logic                          rd_end;

    // every pin passes two flip-flops before the clk_i logic looks at it; the serial front end takes cs_n_i, dc_i and data_i[1] directly
    assign pin_raw = {reset_n_in_i, cs_n_i, dc_i, iface_strap_hi_i, iface_strap_lo_i, rw_wr_n_i, e_rd_n_i, data_i};

    bit_sync #(
        .W (PIN_W)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .async_i (pin_raw),
        .sync_o  (pin_s)
    );

    assign reset_n_s      = pin_s[14];
    assign cs_n_s         = pin_s[13];
    assign dc_s           = pin_s[12];
    assign rw_s           = pin_s[9];
    assign e_s            = pin_s[8];
    assign bus_s          = pin_s[7:0];
    assign cs_n_d         = pin_d[13];
    assign dc_d           = pin_d[12];
    assign rw_d           = pin_d[9];
    assign e_d            = pin_d[8];
    assign bus_d          = pin_d[7:0];
    assign scl_s          = bus_s[0];
    assign sda_s          = bus_s[`SDA_LINE_BIT];
    assign scl_d          = bus_d[0];
    assign sda_d          = bus_d[`SDA_LINE_BIT];
    assign i2c_data_sense = sda_s;
    assign slave_addr_lsb = dc_s;

    always_ff @(posedge clk_i) begin
        pin_d <= pin_s;
    end

    // system reset or the reset pin held low both initialise the port
    always_ff @(posedge clk_i) begin
        init_r <= reset_i | ~reset_n_s;
        init_o <= init_r;
    end

    // straps are taken while initialising; the board keeps them fixed afterwards
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_r <= display_host_pkg::IFACE_SERIAL4;
        end else if (init_r) begin
            mode_r <= display_host_pkg::iface_mode_e'({pin_s[11], pin_s[10]});
        end
    end

    assign mode_o = mode_r;

    // serial front end lives on the host's serial clock
    always_ff @(posedge clk_i) begin
        spi_clear_r <= init_r | (mode_r != display_host_pkg::IFACE_SERIAL4);
    end

    spi_shifter u_spi (
        .sclk_i           (link_clk_i),
        .clear_i          (spi_clear_r),
        .cs_n_i           (cs_n_i),
        .serial_data_in_i (data_i[1]),
        .dc_i             (dc_i),
        .rx_o             (spi_rx),
        .toggle_o         (spi_tog)
    );

    bit_sync #(
        .W (1)
    ) u_tog_sync (
        .clk_i   (clk_i),
        .async_i (spi_tog),
        .sync_o  (spi_tog_s)
    );

    always_ff @(posedge clk_i) begin
        spi_tog_d <= spi_tog_s;
    end

    // i2c conditions seen on the oversampled lines
    assign i2c_start = scl_s & scl_d & sda_d & ~sda_s;
    assign i2c_stop  = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;

    always_ff @(posedge clk_i) begin
        i2c_evt_r <= 1'b0;
        if (init_r || mode_r != display_host_pkg::IFACE_I2C || cs_n_s) begin
            i2c_state_r <= display_host_pkg::I2C_IDLE;
            i2c_phase_r <= display_host_pkg::PH_ADDR;
            i2c_cnt_r   <= 4'h0;
            i2c_sh_r    <= `BYTE_RESET;
            i2c_dc_r    <= 1'b0;
            i2c_drive_r <= 1'b0;
        end else if (i2c_start) begin
            i2c_state_r <= display_host_pkg::I2C_SHIFT;
            i2c_phase_r <= display_host_pkg::PH_ADDR;
            i2c_cnt_r   <= 4'h0;
            i2c_drive_r <= 1'b0;
        end else if (i2c_stop) begin
            i2c_state_r <= display_host_pkg::I2C_IDLE;
            i2c_drive_r <= 1'b0;
        end else begin
            case (i2c_state_r)
                display_host_pkg::I2C_SHIFT: begin
                    if (scl_rise) begin
                        i2c_sh_r  <= {i2c_sh_r[6:0], i2c_data_sense};
                        i2c_cnt_r <= i2c_cnt_r + 4'h1;
                    end else if (scl_fall && i2c_cnt_r == `I2C_BITS_PER_BYTE) begin
                        i2c_cnt_r <= 4'h0;
                        case (i2c_phase_r)
                            display_host_pkg::PH_ADDR: begin
                                if (i2c_sh_r[7:1] == {I2C_ADDR_HI, slave_addr_lsb} &&
                                    i2c_sh_r[0] == `I2C_RW_WRITE) begin
                                    i2c_state_r <= display_host_pkg::I2C_ACK;
                                    i2c_drive_r <= 1'b1;
                                    i2c_phase_r <= display_host_pkg::PH_CTRL;
                                end else begin
                                    i2c_state_r <= display_host_pkg::I2C_IGNORE;
                                end
                            end
                            display_host_pkg::PH_CTRL: begin
                                i2c_dc_r    <= i2c_sh_r[`I2C_CTRL_DC_BIT];
                                i2c_state_r <= display_host_pkg::I2C_ACK;
                                i2c_drive_r <= 1'b1;
                                i2c_phase_r <= display_host_pkg::PH_DATA;
                            end
                            display_host_pkg::PH_DATA: begin
                                i2c_evt_r   <= 1'b1;
                                i2c_state_r <= display_host_pkg::I2C_ACK;
                                i2c_drive_r <= 1'b1;
                            end
                            default: begin
                                i2c_state_r <= display_host_pkg::I2C_IGNORE;
                            end
                        endcase
                    end
                end
                display_host_pkg::I2C_ACK: begin
                    if (scl_fall) begin
                        i2c_drive_r <= 1'b0;
                        i2c_state_r <= display_host_pkg::I2C_SHIFT;
                    end
                end
                display_host_pkg::I2C_IGNORE: begin
                    i2c_drive_r <= 1'b0;
                end
                display_host_pkg::I2C_IDLE: begin
                    i2c_drive_r <= 1'b0;
                end
                default: begin
                    i2c_state_r <= display_host_pkg::I2C_IDLE;
                    i2c_drive_r <= 1'b0;
                end
            endcase
        end
    end

    // write capture uses the sample before the strobe edge, when the bus was still valid
    always_comb begin
        wr_evt     = 1'b0;
        wr_byte    = bus_d;
        wr_is_data = dc_d;
        rd_end     = 1'b0;
        case (mode_r)
            display_host_pkg::IFACE_PAR_RWSEL: begin
                wr_evt = ~cs_n_d & ~rw_d & e_d & ~e_s;
                rd_end = ~cs_n_d & rw_d & e_d & ~e_s;
            end
            display_host_pkg::IFACE_PAR_STROBE: begin
                wr_evt = ~cs_n_d & ~rw_d & rw_s;
                rd_end = ~cs_n_d & ~e_d & e_s;
            end
            display_host_pkg::IFACE_SERIAL4: begin
                wr_evt     = spi_tog_s ^ spi_tog_d;
                wr_byte    = spi_rx.value;
                wr_is_data = spi_rx.is_data;
            end
            display_host_pkg::IFACE_I2C: begin
                wr_evt     = i2c_evt_r;
                wr_byte    = i2c_sh_r;
                wr_is_data = i2c_dc_r;
            end
            default: begin
                wr_evt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (init_r) begin
            cmd_o    <= `BYTE_RESET;
            cmd_we_o <= 1'b0;
        end else begin
            cmd_we_o <= wr_evt & ~wr_is_data;
            if (wr_evt && !wr_is_data) begin
                cmd_o <= wr_byte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (init_r) begin
            disp_data_o <= `BYTE_RESET;
            disp_we_o   <= 1'b0;
        end else begin
            disp_we_o <= wr_evt & wr_is_data;
            if (wr_evt && wr_is_data) begin
                disp_data_o <= wr_byte;
            end
        end
    end

    // column counter advances after each display byte and wraps at the panel width
    always_ff @(posedge clk_i) begin
        if (init_r) begin
            col_addr_o <= COL_W'(`COL_ADDR_RESET);
        end else if (disp_we_o) begin
            if (col_addr_o == COL_W'(NUM_COLS - 8'h01)) begin
                col_addr_o <= COL_W'(`COL_ADDR_RESET);
            end else begin
                col_addr_o <= col_addr_o + COL_W'(1);
            end
        end
    end

    // display stays dark until the command decoder turns it on
    always_ff @(posedge clk_i) begin
        if (init_r) begin
            display_on_o <= 1'b0;
        end else if (disp_on_set_i) begin
            display_on_o <= 1'b1;
        end else if (disp_on_clr_i) begin
            display_on_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_done_o <= ~init_r & rd_end;
    end

    // drive follows the synchronised strobes, so turn-on and release lag the pins by three cycles
    assign par_read = ~cs_n_s &
                      (((mode_r == display_host_pkg::IFACE_PAR_RWSEL) & rw_s & e_s) |
                       ((mode_r == display_host_pkg::IFACE_PAR_STROBE) & ~e_s));

    always_ff @(posedge clk_i) begin
        if (init_r) begin
            data_o    <= `BYTE_RESET;
            data_oe_o <= `BUS_RELEASED;
        end else if (par_read) begin
            data_o    <= rd_data_i;
            data_oe_o <= `BUS_ALL_DRIVEN;
        end else if (i2c_drive_r && mode_r == display_host_pkg::IFACE_I2C) begin
            data_o    <= `BYTE_RESET;
            data_oe_o <= 8'h02;
        end else begin
            data_o    <= `BYTE_RESET;
            data_oe_o <= `BUS_RELEASED;
        end
    end

endmodule : display_host_interface

// [sim/display_host_interface_sva.sv]
// port-level assertions for the display host interface
module dhi_sva #(
    parameter int         COL_W    = 8,
    parameter logic [7:0] NUM_COLS = 8'h04
) (
    input wire logic                          clk_i,
    input wire logic                          reset_i,
    input wire logic                          cs_n_i,
    input wire logic                          iface_strap_hi_i,
    input wire logic                          iface_strap_lo_i,
    input wire logic [7:0]                    rd_data_i,
    input wire logic [7:0]                    data_o,
    input wire logic [7:0]                    data_oe_o,
    input wire logic [7:0]                    cmd_o,
    input wire logic                          cmd_we_o,
    input wire logic [7:0]                    disp_data_o,
    input wire logic                          disp_we_o,
    input wire logic [COL_W-1:0]              col_addr_o,
    input wire logic                          display_on_o,
    input wire display_host_pkg::iface_mode_e mode_o,
    input wire logic                          init_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    mode_sel_a: assert property ($fell(init_o) |-> mode_o == {iface_strap_hi_i, iface_strap_lo_i})
        else $error("mode not taken from straps");
    col_step_a: assert property (disp_we_o |=> col_addr_o == (($past(col_addr_o) == COL_W'(NUM_COLS - 1)) ? '0
        : $past(col_addr_o) + 1'b1))
        else $error("column counter step wrong");
    disp_only_a: assert property ($changed(disp_data_o) |-> disp_we_o || init_o)
        else $error("display byte changed without strobe");
    cmd_only_a: assert property ($changed(cmd_o) |-> cmd_we_o || init_o)
        else $error("command byte changed without strobe");
    cs_gate_a: assert property ((cmd_we_o || disp_we_o) && mode_o[0]
        |-> !$past(cs_n_i, 3) || !$past(cs_n_i, 4) || !$past(cs_n_i, 5))
        else $error("write taken while deselected");
    oe_full_a: assert property (mode_o[0] && data_oe_o != 8'h00 |-> data_oe_o == 8'hff)
        else $error("parallel read not byte wide");
    rd_val_a: assert property (data_oe_o == 8'hff |-> data_o == $past(rd_data_i))
        else $error("read value wrong");
    bus_free_a: assert property (mode_o[0] && $past(cs_n_i, 2) && $past(cs_n_i, 3) && $past(cs_n_i, 4)
        && $past(cs_n_i, 5) |-> data_oe_o == 8'h00)
        else $error("bus driven while deselected");
    serial_in_a: assert property (mode_o == display_host_pkg::IFACE_SERIAL4 |-> data_oe_o == 8'h00)
        else $error("bus driven in serial mode");
    init_clr_a: assert property (init_o |-> data_oe_o == 8'h00 && col_addr_o == '0 && !display_on_o)
        else $error("state not cleared in init");
endmodule : dhi_sva

bind display_host_interface dhi_sva #(.COL_W(COL_W), .NUM_COLS(NUM_COLS)) chk (.clk_i, .reset_i, .cs_n_i,
    .iface_strap_hi_i, .iface_strap_lo_i, .rd_data_i, .data_o, .data_oe_o, .cmd_o, .cmd_we_o, .disp_data_o,
    .disp_we_o, .col_addr_o, .display_on_o, .mode_o, .init_o);

// [sim/host_model.sv]
// host side: parallel and serial bus cycles driven from tasks
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pins_i,
    output logic            cs_n_o,
    output logic            dc_o,
    output logic            rw_wr_n_o,
    output logic            e_rd_n_o,
    output logic            sclk_o,
    output logic [7:0]      bus_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n_o = 1'b1;
        dc_o = 1'b0;
        rw_wr_n_o = 1'b0;
        e_rd_n_o = 1'b0;
        sclk_o = 1'b0;
        bus_o = 8'h00;
    end
    // the separate-strobe style idles high; rw-select, serial and i2c boards ground both pins
    task automatic set_idle(input logic s);
        rw_wr_n_o <= s;
        e_rd_n_o <= s;
    endtask : set_idle
    task automatic par_write(input logic s, input logic cs, input logic dc, input logic [7:0] b);
        @(posedge clk_i);
        cs_n_o <= cs;
        dc_o <= dc;
        bus_o <= b;
        rw_wr_n_o <= s;
        repeat (2) @(posedge clk_i);
        if (s) rw_wr_n_o <= 1'b0;
        else e_rd_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        if (s) rw_wr_n_o <= 1'b1;
        else e_rd_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // released lines show the inverse so a stale byte cannot pass
        bus_o <= ~b;
        repeat (18) @(posedge clk_i);
    endtask : par_write
    task automatic par_read(input logic s, output logic [7:0] got);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        rw_wr_n_o <= 1'b1;
        bus_o <= ~bus_o;
        repeat (2) @(posedge clk_i);
        e_rd_n_o <= !s;
        repeat (8) @(posedge clk_i);
        #1 got = pins_i;
        @(posedge clk_i);
        e_rd_n_o <= s;
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b1;
        rw_wr_n_o <= s;
        repeat (18) @(posedge clk_i);
    endtask : par_read
    // link clock runs only inside the frame, 160 ns period
    task automatic spi_byte(input logic dc, input logic [7:0] b);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        dc_o <= dc;
        #23;
        for (int i = 7; i >= 0; i--) begin
            bus_o = {5'h00, b[i], b[i], 1'b0};
            #80;
            sclk_o = 1'b1;
            bus_o[0] = 1'b1;
            #80;
            sclk_o = 1'b0;
            bus_o[0] = 1'b0;
        end
        repeat (10) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (10) @(posedge clk_i);
    endtask : spi_byte
endmodule : host_model

// [sim/display_host_interface_tb.sv]
// self-checking bench for the display host interface
module display_host_interface_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] COLS = 8'h04;
    localparam logic [7:0] RDV  = 8'h5a;
    logic       clk_i = 1'b0, reset_i = 1'b1, reset_n_in_i = 1'b1;
    logic       iface_strap_hi_i = 1'b0, iface_strap_lo_i = 1'b0;
    logic       disp_on_set_i = 1'b0, disp_on_clr_i = 1'b0;
    logic [7:0] rd_data_i = RDV;
    wire logic  cs_n_i, dc_i, rw_wr_n_i, e_rd_n_i, link_clk_i;
    wire logic [7:0] bus, data_i;
    logic [7:0] data_o, data_oe_o, cmd_o, disp_data_o, col_addr_o, got_cmd, got_disp, col_exp;
    logic       cmd_we_o, disp_we_o, display_on_o, rd_done_o, init_o;
    display_host_pkg::iface_mode_e mode_o;
    int         fail_count = 0, check_count = 0, cmd_cnt = 0, disp_cnt = 0, done_cnt = 0;

    always #5 clk_i = ~clk_i;
    assign data_i = (data_oe_o & data_o) | (~data_oe_o & bus);

    display_host_interface #(.COL_W(8), .NUM_COLS(COLS)) dut (.clk_i, .reset_i, .link_clk_i, .reset_n_in_i,
        .cs_n_i, .dc_i, .iface_strap_hi_i, .iface_strap_lo_i, .rw_wr_n_i, .e_rd_n_i, .data_i, .rd_data_i,
        .disp_on_set_i, .disp_on_clr_i, .data_o, .data_oe_o, .cmd_o, .cmd_we_o, .disp_data_o, .disp_we_o,
        .col_addr_o, .display_on_o, .rd_done_o, .mode_o, .init_o);
    host_model host (.clk_i, .pins_i(data_i), .cs_n_o(cs_n_i), .dc_o(dc_i), .rw_wr_n_o(rw_wr_n_i),
        .e_rd_n_o(e_rd_n_i), .sclk_o(link_clk_i), .bus_o(bus));

    // pulses are one cycle wide, so they are logged as they pass
    always @(posedge clk_i) begin
        if (cmd_we_o === 1'b1) begin
            cmd_cnt++;
            got_cmd = cmd_o;
        end
        if (disp_we_o === 1'b1) begin
            disp_cnt++;
            got_disp = disp_data_o;
        end
        if (rd_done_o === 1'b1) done_cnt++;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic start(input logic [1:0] m);
        @(posedge clk_i);
        {iface_strap_hi_i, iface_strap_lo_i} <= m;
        reset_i <= 1'b1;
        host.set_idle(m == 2'h3);
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("mode", {6'h00, m}, {6'h00, mode_o});
        col_exp = 8'h00;
    endtask : start
    // k: 0 rw-select, 1 separate strobes, 2 serial
    task automatic wr(input logic [1:0] k, input logic dc, input logic [7:0] b);
        int c0;
        int d0;
        c0 = cmd_cnt;
        d0 = disp_cnt;
        if (k == 2'h2) host.spi_byte(dc, b);
        else host.par_write(k[0], 1'b0, dc, b);
        if (dc) col_exp = (col_exp + 8'h01) % COLS;
        check("cmd count", {7'h00, !dc}, 8'(cmd_cnt - c0));
        check("disp count", {7'h00, dc}, 8'(disp_cnt - d0));
        check("byte", b, dc ? got_disp : got_cmd);
        check("column", col_exp, col_addr_o);
    endtask : wr
    task automatic rd(input logic s);
        logic [7:0] got;
        int         r0;
        r0 = done_cnt;
        host.par_read(s, got);
        check("read byte", RDV, got);
        check("read done", 8'h01, 8'(done_cnt - r0));
        check("bus idle", 8'h00, data_oe_o);
    endtask : rd

    initial begin
        start(2'h2);
        $display("test i2c strap ended");
        start(2'h1);
        wr(2'h0, 1'b0, 8'haf);
        for (int i = 0; i < 5; i++) wr(2'h0, 1'b1, 8'(8'h10 + i));
        rd(1'b0);
        host.par_write(1'b0, 1'b1, 1'b0, 8'hee);
        check("deselected write", 8'haf, got_cmd);
        check("deselected count", 8'h01, 8'(cmd_cnt));
        @(posedge clk_i);
        disp_on_set_i <= 1'b1;
        @(posedge clk_i);
        disp_on_set_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("display on", 8'h01, {7'h00, display_on_o});
        reset_n_in_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check("init high", 8'h01, {7'h00, init_o});
        reset_n_in_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("init low", 8'h00, {7'h00, init_o});
        check("column reset", 8'h00, col_addr_o);
        check("display off", 8'h00, {7'h00, display_on_o});
        $display("test rw-select ended");
        start(2'h3);
        wr(2'h1, 1'b0, 8'h81);
        wr(2'h1, 1'b1, 8'h7e);
        rd(1'b1);
        $display("test strobe ended");
        start(2'h0);
        host.spi_byte(1'b0, 8'h00);
        wr(2'h2, 1'b0, 8'hc3);
        wr(2'h2, 1'b1, 8'h96);
        $display("test serial ended");
        end_sim;
    end

    initial begin
        #400_000;
        fail_count++;
        end_sim;
    end
endmodule : display_host_interface_tb
